// [hdl/tcsel_pkg.sv]
// Shared constants and types of the timer clock-select and timer 3 block.
// Assumes a single 50 MHz system clock and an APB master with 32-bit data.
package tcsel_pkg;

	// Register byte addresses on APB
	localparam logic [7:0] ADDR_CLK_CTRL = 8'h00;
	localparam logic [7:0] ADDR_TMR3_CTRL = 8'h04;
	localparam logic [7:0] ADDR_TMR3_COUNT_LOW = 8'h08;
	localparam logic [7:0] ADDR_TMR3_COUNT_HIGH = 8'h0c;
	localparam logic [7:0] ADDR_TMR3_RELOAD_LOW = 8'h10;
	localparam logic [7:0] ADDR_TMR3_RELOAD_HIGH = 8'h14;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h1c;
	localparam logic [7:0] ADDR_TMR012_CFG = 8'h20;

	// timer_clock_control fields
	localparam int CK_TMR3_HI_SEL = 7;
	localparam int CK_TMR3_LO_SEL = 6;
	localparam int CK_TMR2_HI_SEL = 5;
	localparam int CK_TMR2_LO_SEL = 4;
	localparam int CK_TMR1_SEL = 3;
	localparam int CK_TMR0_SEL = 2;
	localparam int CK_PRESCALE_LSB = 0;

	// tmr3_control fields
	localparam int T3_HI_OVF = 7;
	localparam int T3_LO_OVF = 6;
	localparam int T3_LO_IRQ_EN = 5;
	localparam int T3_SPLIT = 3;
	localparam int T3_RUN = 2;
	localparam int T3_EXT_SEL = 0;

	// Timer 0/1/2 configuration fields
	localparam int CFG_TMR0_COUNTER = 0;
	localparam int CFG_TMR1_COUNTER = 1;
	localparam int CFG_TMR2_EXT_SEL = 2;

	// Interrupt status and mask fields
	localparam int IRQ_HI = 0;
	localparam int IRQ_LO = 1;

	// Reset values
	localparam logic [7:0] CLK_CTRL_RESET = 8'h00;
	localparam logic [7:0] TMR3_CTRL_RESET = 8'h00;
	localparam logic [7:0] TMR012_CFG_RESET = 8'h00;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [1:0] IRQ_RESET = 2'h0;

	// Prescale codes
	localparam logic [1:0] PS_DIV12 = 2'h0;
	localparam logic [1:0] PS_DIV4_A = 2'h1;
	localparam logic [1:0] PS_DIV4_B = 2'h2;
	localparam logic [1:0] PS_EXT8 = 2'h3;

	// Division ratios
	localparam int DIV_SYS12 = 12;
	localparam int DIV_SYS4 = 4;
	localparam int DIV_EXT8 = 8;

	typedef struct packed {
		logic tmr0;
		logic tmr1;
		logic tmr2Lo;
		logic tmr2Hi;
	} tcsel_ticks_type;

	typedef struct packed {
		logic [7:0] count;
		logic pulse;
	} tcsel_div_state_type;

	typedef struct packed {
		logic stage1;
		logic stage2;
		logic stage3;
		logic rise;
	} tcsel_sync_state_type;

	typedef struct packed {
		logic [7:0] clkCtrl;
		logic [7:0] tmr3Ctrl;
		logic [7:0] cfg;
		logic [7:0] countLow;
		logic [7:0] countHigh;
		logic [7:0] reloadLow;
		logic [7:0] reloadHigh;
		logic [1:0] irqStatus;
		logic [1:0] irqMask;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		tcsel_ticks_type ticks;
		logic irq;
	} tcsel_state_type;

endpackage

// [hdl/tcsel_divider.sv]
// Enable divider: one output pulse for every DIV input enables.
// Assumes inEn is a one-cycle enable in the clk domain.
`timescale 1ns/1ps
module tcsel_divider #(
	parameter int DIV = 12
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic inEn,
	output logic pulse
);
	localparam logic [7:0] LAST = 8'(DIV - 1);

	tcsel_pkg::tcsel_div_state_type st;
	tcsel_pkg::tcsel_div_state_type next_st;

	always_comb
	begin
		next_st = st;
		next_st.pulse = 1'b0;
		if (inEn)
		begin
			if (st.count == LAST)
			begin
				next_st.count = 8'h00;
				next_st.pulse = 1'b1;
			end
			else
			begin
				next_st.count = st.count + 8'h01;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			st <= '0;
		else
			st <= next_st;
	end

	assign pulse = st.pulse;
endmodule

// [hdl/tcsel_ext_sync.sv]
// Brings the external oscillator into the system clock domain and marks its rising edges.
// Assumes the oscillator runs well below half the system clock rate.
`timescale 1ns/1ps
module tcsel_ext_sync (
	input wire logic clk,
	input wire logic nrst,
	input wire logic extOsc,
	output logic extRise
);
	tcsel_pkg::tcsel_sync_state_type st;
	tcsel_pkg::tcsel_sync_state_type next_st;

	always_comb
	begin
		next_st.stage1 = extOsc;
		next_st.stage2 = st.stage1;
		next_st.stage3 = st.stage2;
		// Edge taken past the second stage so the metastable flop feeds nothing else
		next_st.rise = st.stage2 & ~st.stage3;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			st <= '0;
		else
			st <= next_st;
	end

	assign extRise = st.rise;
endmodule

// [hdl/tcsel_top.sv]
// Timer clock selection for timers 0, 1, 2 and the timer 3 auto-reload counter with APB registers.
// Assumes one 50 MHz clock, an APB master, and external event pulses already synchronous to clk.
//
// Summary of operation
// - Timer 2 high counter clock: external-select clock at 0, system clock at 1.
// - Timer 2 low counter clock: external-select clock at 0, system clock at 1.
// - Timer 1 uses prescaler at 0, system clock at 1; ignored in counter mode.
// - Timer 0 uses prescaler at 0, system clock at 1; ignored in counter mode.
// - Prescale field: 00 div12, 01 div4, 10 div4, 11 synchronised external div8.
// - Timer 3 is two 8-bit counts; split bit picks 16-bit or dual 8-bit.
// - Timer 3 clocks: system clock, system clock div12, or synchronised external div8.
// - 16-bit rollover loads the reload value and sets the high overflow flag.
// - With timer 3 interrupts enabled, every 16-bit overflow requests an interrupt.
// - Low byte overflow also interrupts when low interrupt enable and mask bits 0 and 1 are set.
// - Split mode: each byte reloads from its own reload register on overflow.
// - Split mode: run bit gates only the high byte; low byte always counts.
// - Split mode: each byte picks system clock or external-select clock by own bit.
// - Timer 3 high select is bit 7, low select bit 6 of clock control.
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
module tcsel_top (
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic extOsc,
	input wire logic tmr0Event,
	input wire logic tmr1Event,
	output tcsel_pkg::tcsel_ticks_type ticks,
	output logic irq
);
	tcsel_pkg::tcsel_state_type st;
	tcsel_pkg::tcsel_state_type next_st;

	logic extRise;
	logic div12Pulse;
	logic div4Pulse;
	logic ext8Pulse;

	tcsel_ext_sync u_sync (
		.clk(clk),
		.nrst(nrst),
		.extOsc(extOsc),
		.extRise(extRise)
	);

	tcsel_divider #(
		.DIV(tcsel_pkg::DIV_SYS12)
	) u_div12 (
		.clk(clk),
		.nrst(nrst),
		.inEn(1'b1),
		.pulse(div12Pulse)
	);

	tcsel_divider #(
		.DIV(tcsel_pkg::DIV_SYS4)
	) u_div4 (
		.clk(clk),
		.nrst(nrst),
		.inEn(1'b1),
		.pulse(div4Pulse)
	);

	// External divide happens after synchronisation, so the count never sees a raw edge
	tcsel_divider #(
		.DIV(tcsel_pkg::DIV_EXT8)
	) u_ext8 (
		.clk(clk),
		.nrst(nrst),
		.inEn(extRise),
		.pulse(ext8Pulse)
	);

	logic setupDone;
	logic access;
	logic hit;
	logic [7:0] readByte;
	logic [1:0] prescale;
	logic prescaled;
	logic tmr2Base;
	logic tmr3Base;
	logic tmr3LoTick;
	logic tmr3HiTick;
	logic hiOvf;
	logic loOvf;
	logic [15:0] count16;
	logic [1:0] irqEffMask;
	logic [3:0] selSys;
	logic [3:0] selBase;
	logic [3:0] selTick;

	assign setupDone = psel && penable && !st.pready;
	assign access = psel && penable && st.pready;
	assign prescale = st.clkCtrl[tcsel_pkg::CK_PRESCALE_LSB +: 2];

	// Read multiplexer and address decode
	always_comb
	begin
		hit = 1'b1;
		readByte = 8'h00;
		case (paddr)
			tcsel_pkg::ADDR_CLK_CTRL: readByte = st.clkCtrl;
			tcsel_pkg::ADDR_TMR3_CTRL: readByte = st.tmr3Ctrl;
			tcsel_pkg::ADDR_TMR3_COUNT_LOW: readByte = st.countLow;
			tcsel_pkg::ADDR_TMR3_COUNT_HIGH: readByte = st.countHigh;
			tcsel_pkg::ADDR_TMR3_RELOAD_LOW: readByte = st.reloadLow;
			tcsel_pkg::ADDR_TMR3_RELOAD_HIGH: readByte = st.reloadHigh;
			tcsel_pkg::ADDR_IRQ_STATUS: readByte = {6'h00, st.irqStatus};
			tcsel_pkg::ADDR_IRQ_MASK: readByte = {6'h00, st.irqMask};
			tcsel_pkg::ADDR_TMR012_CFG: readByte = st.cfg;
			default: hit = 1'b0;
		endcase
	end

	// Clock selection for all timers
	always_comb
	begin
		case (prescale)
			tcsel_pkg::PS_DIV12: prescaled = div12Pulse;
			tcsel_pkg::PS_DIV4_A: prescaled = div4Pulse;
			tcsel_pkg::PS_DIV4_B: prescaled = div4Pulse;
			tcsel_pkg::PS_EXT8: prescaled = ext8Pulse;
			default: prescaled = div12Pulse;
		endcase
		tmr2Base = st.cfg[tcsel_pkg::CFG_TMR2_EXT_SEL] ? ext8Pulse : div12Pulse;
		tmr3Base = st.tmr3Ctrl[tcsel_pkg::T3_EXT_SEL] ? ext8Pulse : div12Pulse;
	end

	// One selector per byte counter: bit 0 timer 2 low, 1 timer 2 high, 2 timer 3 low, 3 timer 3 high
	assign selSys = {st.clkCtrl[tcsel_pkg::CK_TMR3_HI_SEL], st.clkCtrl[tcsel_pkg::CK_TMR3_LO_SEL],
		st.clkCtrl[tcsel_pkg::CK_TMR2_HI_SEL], st.clkCtrl[tcsel_pkg::CK_TMR2_LO_SEL]};
	assign selBase = {tmr3Base, tmr3Base, tmr2Base, tmr2Base};
	for (genvar gi = 0; gi < 4; gi++)
	begin : g_sel
		// The system clock is an enable that stands high on every cycle
		assign selTick[gi] = selSys[gi] ? 1'b1 : selBase[gi];
	end
	assign tmr3LoTick = selTick[2];
	assign tmr3HiTick = selTick[3];

	always_comb
	begin
		next_st = st;
		hiOvf = 1'b0;
		loOvf = 1'b0;
		count16 = {st.countHigh, st.countLow};

		// Timer 0 and 1: counter mode passes the external event and ignores the select bit
		if (st.cfg[tcsel_pkg::CFG_TMR0_COUNTER])
			next_st.ticks.tmr0 = tmr0Event;
		else
			next_st.ticks.tmr0 = st.clkCtrl[tcsel_pkg::CK_TMR0_SEL] ? 1'b1 : prescaled;
		if (st.cfg[tcsel_pkg::CFG_TMR1_COUNTER])
			next_st.ticks.tmr1 = tmr1Event;
		else
			next_st.ticks.tmr1 = st.clkCtrl[tcsel_pkg::CK_TMR1_SEL] ? 1'b1 : prescaled;
		next_st.ticks.tmr2Lo = selTick[0];
		next_st.ticks.tmr2Hi = selTick[1];

		// Timer 3 counting
		if (!st.tmr3Ctrl[tcsel_pkg::T3_SPLIT])
		begin
			// The low select bit clocks the whole counter in 16-bit mode
			if (st.tmr3Ctrl[tcsel_pkg::T3_RUN] && tmr3LoTick)
			begin
				loOvf = (st.countLow == 8'hff);
				if (count16 == 16'hffff)
				begin
					count16 = {st.reloadHigh, st.reloadLow};
					hiOvf = 1'b1;
				end
				else
				begin
					count16 = count16 + 16'h0001;
				end
				next_st.countLow = count16[7:0];
				next_st.countHigh = count16[15:8];
			end
		end
		else
		begin
			// Low byte runs whatever the run bit says
			if (tmr3LoTick)
			begin
				if (st.countLow == 8'hff)
				begin
					next_st.countLow = st.reloadLow;
					loOvf = 1'b1;
				end
				else
				begin
					next_st.countLow = st.countLow + 8'h01;
				end
			end
			if (st.tmr3Ctrl[tcsel_pkg::T3_RUN] && tmr3HiTick)
			begin
				if (st.countHigh == 8'hff)
				begin
					next_st.countHigh = st.reloadHigh;
					hiOvf = 1'b1;
				end
				else
				begin
					next_st.countHigh = st.countHigh + 8'h01;
				end
			end
		end

		// APB: one wait state, answer registered at the end of the first access cycle
		next_st.pready = setupDone;
		if (setupDone)
		begin
			next_st.prdata = pwrite ? 32'h00000000 : {24'h000000, readByte};
			next_st.pslverr = !hit;
		end
		else if (!psel)
		begin
			next_st.pslverr = 1'b0;
		end

		if (access && pwrite)
		begin
			case (paddr)
				tcsel_pkg::ADDR_CLK_CTRL: next_st.clkCtrl = pwdata[7:0];
				tcsel_pkg::ADDR_TMR3_CTRL: next_st.tmr3Ctrl = pwdata[7:0];
				tcsel_pkg::ADDR_TMR3_COUNT_LOW: next_st.countLow = pwdata[7:0];
				tcsel_pkg::ADDR_TMR3_COUNT_HIGH: next_st.countHigh = pwdata[7:0];
				tcsel_pkg::ADDR_TMR3_RELOAD_LOW: next_st.reloadLow = pwdata[7:0];
				tcsel_pkg::ADDR_TMR3_RELOAD_HIGH: next_st.reloadHigh = pwdata[7:0];
				tcsel_pkg::ADDR_IRQ_MASK: next_st.irqMask = pwdata[1:0];
				tcsel_pkg::ADDR_TMR012_CFG: next_st.cfg = pwdata[7:0];
				default: next_st.cfg = st.cfg;
			endcase
		end
		if (access && !pwrite && paddr == tcsel_pkg::ADDR_IRQ_STATUS)
			next_st.irqStatus = 2'h0;

		// Hardware set wins over a software clear in the same cycle
		if (hiOvf)
		begin
			next_st.tmr3Ctrl[tcsel_pkg::T3_HI_OVF] = 1'b1;
			next_st.irqStatus[tcsel_pkg::IRQ_HI] = 1'b1;
		end
		if (loOvf)
			next_st.tmr3Ctrl[tcsel_pkg::T3_LO_OVF] = 1'b1;
		if (loOvf && st.tmr3Ctrl[tcsel_pkg::T3_LO_IRQ_EN])
			next_st.irqStatus[tcsel_pkg::IRQ_LO] = 1'b1;

		// Mask bit 0 is the timer 3 interrupt enable; the low source also needs it
		irqEffMask[tcsel_pkg::IRQ_HI] = next_st.irqMask[tcsel_pkg::IRQ_HI];
		irqEffMask[tcsel_pkg::IRQ_LO] = next_st.irqMask[tcsel_pkg::IRQ_LO]
			& next_st.irqMask[tcsel_pkg::IRQ_HI]
			& next_st.tmr3Ctrl[tcsel_pkg::T3_LO_IRQ_EN];
		next_st.irq = |(next_st.irqStatus & irqEffMask);
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st <= '0;
			st.clkCtrl <= tcsel_pkg::CLK_CTRL_RESET;
			st.tmr3Ctrl <= tcsel_pkg::TMR3_CTRL_RESET;
			st.cfg <= tcsel_pkg::TMR012_CFG_RESET;
			st.countLow <= tcsel_pkg::BYTE_RESET;
			st.countHigh <= tcsel_pkg::BYTE_RESET;
			st.reloadLow <= tcsel_pkg::BYTE_RESET;
			st.reloadHigh <= tcsel_pkg::BYTE_RESET;
			st.irqStatus <= tcsel_pkg::IRQ_RESET;
			st.irqMask <= tcsel_pkg::IRQ_RESET;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign ticks = st.ticks;
	assign irq = st.irq;
endmodule

// [testbench/tcsel_sva.sv]
// Checker of the APB answer, interrupt and tick outputs of tcsel_top.
// Assumes it is bound to tcsel_top; the shadows follow completed APB writes.
`timescale 1ns/1ps
module tcsel_sva (
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic extOsc,
	input wire logic tmr0Event,
	input wire logic tmr1Event,
	input wire tcsel_pkg::tcsel_ticks_type ticks,
	input wire logic irq
);
	logic [7:0] ck;
	logic [7:0] cfg;
	logic mk;
	logic wrDone;
	assign wrDone = psel && penable && pready && pwrite;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	// Selections are known only from completed writes, not from inside the design
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ck <= 8'h00;
			cfg <= 8'h00;
			mk <= 1'b0;
		end
		else if (wrDone && paddr == tcsel_pkg::ADDR_CLK_CTRL)
			ck <= pwdata[7:0];
		else if (wrDone && paddr == tcsel_pkg::ADDR_TMR012_CFG)
			cfg <= pwdata[7:0];
		else if (wrDone && paddr == tcsel_pkg::ADDR_IRQ_MASK)
			mk <= pwdata[0];
	end
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence
	property p_answer;
		s_setup ##1 s_access |-> !pready ##1 pready;
	endproperty
	a_answer: assert property (p_answer) else $error("pready not in second access cycle");
	property p_pulse;
		pready |=> !pready;
	endproperty
	a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
	property p_unmapped;
		pready && paddr > tcsel_pkg::ADDR_TMR012_CFG |-> pslverr && prdata == 32'h00000000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
	property p_mask;
		wrDone && paddr == tcsel_pkg::ADDR_IRQ_MASK && !pwdata[0] |=> !irq [*3];
	endproperty
	a_mask: assert property (p_mask) else $error("irq high while disabled");
	property p_t2hi;
		ck[5] && $past(ck[5]) |-> ticks.tmr2Hi;
	endproperty
	a_t2hi: assert property (p_t2hi) else $error("timer 2 high not on system clock");
	property p_t2lo;
		ck[4] && $past(ck[4]) |-> ticks.tmr2Lo;
	endproperty
	a_t2lo: assert property (p_t2lo) else $error("timer 2 low not on system clock");
	property p_t1;
		ck[3] && !cfg[1] && $past(ck[3] && !cfg[1]) |-> ticks.tmr1;
	endproperty
	a_t1: assert property (p_t1) else $error("timer 1 not on system clock");
	property p_t0evt;
		cfg[0] && $past(cfg[0]) |-> ticks.tmr0 == $past(tmr0Event);
	endproperty
	a_t0evt: assert property (p_t0evt) else $error("timer 0 not following events");
	property p_t1evt;
		cfg[1] && $past(cfg[1]) |-> ticks.tmr1 == $past(tmr1Event);
	endproperty
	a_t1evt: assert property (p_t1evt) else $error("timer 1 not following events");
	property p_irq_off;
		!mk |-> !irq;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq high with timer 3 interrupts disabled");
endmodule
bind tcsel_top tcsel_sva u_sva (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .extOsc(extOsc),
	.tmr0Event(tmr0Event), .tmr1Event(tmr1Event), .ticks(ticks), .irq(irq));

// [testbench/tcsel_tb_top.sv]
// Self-checking bench of tcsel_top: registers, prescaler ticks and timer 3.
// Assumes a 50 MHz clock; the oscillator runs at one eighth of it, so its tick comes every 64 cycles.
`timescale 1ns/1ps
module tcsel_tb_top;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic extOsc = 1'b0;
	logic tmr0Event = 1'b0;
	logic tmr1Event = 1'b0;
	tcsel_pkg::tcsel_ticks_type ticks;
	logic irq;
	logic [31:0] r;
	logic e;
	logic [2:0] oscDiv = 3'h0;
	int failures = 0;
	int n_checks = 0;
	int cycles = 0;
	tcsel_top dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .extOsc(extOsc),
		.tmr0Event(tmr0Event), .tmr1Event(tmr1Event), .ticks(ticks), .irq(irq));
	always #10 clk = ~clk;
	always @(posedge clk)
	begin
		oscDiv <= oscDiv + 3'h1;
		extOsc <= oscDiv[2];
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			failures++;
			report_and_stop();
		end
	end
	task report_and_stop;
	begin
		if (failures == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
	begin
		n_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	end
	endtask
	// One full transfer; the gap cycle before setup keeps back-to-back calls from double driving
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
	begin
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Read right after the edge, the outputs still hold what the design showed at it
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		chk("pready", pready, 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	end
	endtask
	// Second gap is taken, since the first may start inside a pulse or a divider restart
	task gap(input string what, input int b, input int exp);
		int g;
	begin
		repeat (2)
		begin
			g = 0;
			while (ticks[b] !== 1'b1 && g < 300)
			begin
				@(negedge clk);
				g++;
			end
			g = 0;
			do
			begin
				@(negedge clk);
				g++;
			end
			while (ticks[b] !== 1'b1 && g < 300);
		end
		chk(what, g, exp);
	end
	endtask
	task t_regs;
	begin
		apb(1'b0, tcsel_pkg::ADDR_CLK_CTRL, 32'h0);
		chk("clock control reset", r, 32'h0);
		apb(1'b1, 8'h24, 32'hff);
		apb(1'b0, 8'h24, 32'h0);
		chk("unmapped data", r, 32'h0);
		chk("unmapped error", e, 1'b1);
	end
	endtask
	task t_prescale;
		int exp[4];
	begin
		exp = '{12, 4, 4, 64};
		for (int i = 0; i < 4; i++)
		begin
			apb(1'b1, tcsel_pkg::ADDR_CLK_CTRL, i);
			gap("timer 0 prescale", 3, exp[i]);
		end
		apb(1'b1, tcsel_pkg::ADDR_CLK_CTRL, 32'h3c);
		gap("timer 1 system", 2, 1);
		gap("timer 2 high system", 0, 1);
		apb(1'b1, tcsel_pkg::ADDR_TMR012_CFG, 32'h3);
		repeat (4) @(negedge clk);
		chk("timer 0 counter idle", ticks.tmr0, 1'b0);
		chk("timer 1 counter idle", ticks.tmr1, 1'b0);
		@(posedge clk) tmr0Event <= 1'b1;
		@(posedge clk)
		begin
			tmr0Event <= 1'b0;
			tmr1Event <= 1'b1;
		end
		@(negedge clk);
		chk("timer 0 counter event", ticks.tmr0, 1'b1);
		chk("timer 1 counter still", ticks.tmr1, 1'b0);
		@(posedge clk) tmr1Event <= 1'b0;
		@(negedge clk);
		chk("timer 1 counter event", ticks.tmr1, 1'b1);
		apb(1'b1, tcsel_pkg::ADDR_CLK_CTRL, 32'h0);
		apb(1'b1, tcsel_pkg::ADDR_TMR012_CFG, 32'h0);
		gap("timer 2 low div12", 1, 12);
		apb(1'b1, tcsel_pkg::ADDR_TMR012_CFG, 32'h4);
		gap("timer 2 high ext", 0, 64);
	end
	endtask
	task t_wide;
	begin
		apb(1'b1, tcsel_pkg::ADDR_CLK_CTRL, 32'h40);
		apb(1'b1, tcsel_pkg::ADDR_TMR3_RELOAD_LOW, 32'hfe);
		apb(1'b1, tcsel_pkg::ADDR_TMR3_RELOAD_HIGH, 32'hff);
		apb(1'b1, tcsel_pkg::ADDR_TMR3_COUNT_LOW, 32'hfe);
		apb(1'b1, tcsel_pkg::ADDR_TMR3_COUNT_HIGH, 32'hff);
		apb(1'b1, tcsel_pkg::ADDR_IRQ_MASK, 32'h3);
		apb(1'b1, tcsel_pkg::ADDR_TMR3_CTRL, 32'h24);
		apb(1'b0, tcsel_pkg::ADDR_TMR3_CTRL, 32'h0);
		chk("overflow flags", r[7:6], 2'h3);
		chk("irq running", irq, 1'b1);
		apb(1'b1, tcsel_pkg::ADDR_TMR3_CTRL, 32'h20);
		apb(1'b0, tcsel_pkg::ADDR_TMR3_COUNT_HIGH, 32'h0);
		chk("count high reload", r, 32'hff);
		apb(1'b0, tcsel_pkg::ADDR_TMR3_COUNT_LOW, 32'h0);
		chk("count low reload", r[7:1], 7'h7f);
		apb(1'b0, tcsel_pkg::ADDR_IRQ_STATUS, 32'h0);
		chk("status both", r, 32'h3);
		apb(1'b0, tcsel_pkg::ADDR_IRQ_STATUS, 32'h0);
		chk("status cleared", r, 32'h0);
		chk("irq cleared", irq, 1'b0);
		apb(1'b1, tcsel_pkg::ADDR_IRQ_MASK, 32'h0);
		apb(1'b1, tcsel_pkg::ADDR_TMR3_CTRL, 32'h04);
		apb(1'b1, tcsel_pkg::ADDR_TMR3_CTRL, 32'h00);
		chk("irq masked", irq, 1'b0);
		apb(1'b0, tcsel_pkg::ADDR_IRQ_STATUS, 32'h0);
		chk("status high only", r, 32'h1);
	end
	endtask
	task t_split;
	begin
		apb(1'b1, tcsel_pkg::ADDR_TMR3_RELOAD_LOW, 32'ha0);
		apb(1'b1, tcsel_pkg::ADDR_TMR3_COUNT_LOW, 32'ha0);
		apb(1'b1, tcsel_pkg::ADDR_TMR3_COUNT_HIGH, 32'h55);
		apb(1'b1, tcsel_pkg::ADDR_TMR3_RELOAD_HIGH, 32'hf0);
		apb(1'b1, tcsel_pkg::ADDR_TMR3_CTRL, 32'h08);
		repeat (600) @(posedge clk);
		apb(1'b0, tcsel_pkg::ADDR_TMR3_COUNT_HIGH, 32'h0);
		chk("high stopped", r, 32'h55);
		apb(1'b0, tcsel_pkg::ADDR_TMR3_COUNT_LOW, 32'h0);
		chk("low reloaded", r[7:5] >= 3'h5, 1'b1);
		apb(1'b0, tcsel_pkg::ADDR_TMR3_CTRL, 32'h0);
		chk("low flag only", r[7:6], 2'h1);
		apb(1'b1, tcsel_pkg::ADDR_TMR3_COUNT_HIGH, 32'hfe);
		apb(1'b1, tcsel_pkg::ADDR_TMR3_CTRL, 32'h0c);
		// 30 edges from the run write to the read hold two or three ticks of twelve
		repeat (28) @(posedge clk);
		apb(1'b0, tcsel_pkg::ADDR_TMR3_COUNT_HIGH, 32'h0);
		chk("high div12 reload", r[7:1], 7'h78);
		apb(1'b1, tcsel_pkg::ADDR_TMR3_CTRL, 32'h09);
		apb(1'b1, tcsel_pkg::ADDR_TMR3_COUNT_HIGH, 32'hfe);
		apb(1'b1, tcsel_pkg::ADDR_TMR3_CTRL, 32'h0d);
		// 150 edges hold two or three ticks of the 64-cycle external source
		repeat (148) @(posedge clk);
		apb(1'b0, tcsel_pkg::ADDR_TMR3_COUNT_HIGH, 32'h0);
		chk("high ext8 reload", r[7:1], 7'h78);
	end
	endtask
	initial
	begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		t_regs();
		t_prescale();
		t_wide();
		t_split();
		report_and_stop();
	end
endmodule
